// *** crc_engine_pkg.sv ***
`default_nettype none
package crc_engine_pkg;
    localparam int          DATA_W        = 16;
    localparam int          LEN_W         = 4;
    localparam int          FIFO_DEPTH    = 16;
    localparam logic [15:0] ACC_RST       = 16'h0000;
    localparam logic [15:0] POLY_RST      = 16'h0000;
    localparam logic [3:0]  LEN_RST       = 4'h0;
    localparam logic [4:0]  POLY_LENGTH_FIELD_OFFSET   = 5'h02;
    localparam logic [4:0]  WORD_LENGTH_FIELD_OFFSET   = 5'h01;
    localparam logic [15:0] POLY_BIT0_MSK = 16'hFFFE;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_AUG} engine_state_t;
endpackage : crc_engine_pkg
`default_nettype wire

// *** word_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_q[rd_q];

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE9
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule : word_fifo
`default_nettype wire

// *** configurable_crc_engine.sv ***
// What this block does
// RULE1 - polynomial degree taken from 4-bit field holding degree minus one
// RULE2 - coefficients in bits 15:1; top term and bit 0 forced one; bit 0 reads zero
// RULE3 - only data bits up to programmed length are used; higher bits ignored
// RULE4 - word length field is length minus one; that many plus one bits shifted
// RULE5 - order select clear shifts msb first, set shifts lsb first
// RULE6 - xor shift register division; words pass an intermediate shifter
// RULE7 - accumulator written before start acts as seed
// RULE8 - low byte write latches word; high byte written first for wide words
// RULE9 - pending flag tells software when another word may be written
// RULE10 - augment set appends polynomial-length zero bits after data
// RULE11 - augment clear stops after last data bit
// RULE12 - done flag set on every busy fall, regardless of enable; enable gates request
// RULE13 - done flag cleared only by software write
// RULE14 - go bit starts the shifting process
// RULE15 - scanner loads words whenever the engine accepts them while its go is set
// RULE16 - final check value held in accumulator once busy clears
// RULE17 - ready to scanner shown while go bit set; code also drops it while fifo full or on a low byte write
// RULE18 - busy while words or zeros remain; pending while the word fifo is full
`timescale 1ns/1ps
`default_nettype none
module configurable_crc_engine #(
    parameter int WORD_W = crc_engine_pkg::DATA_W,
    parameter int DEPTH  = crc_engine_pkg::FIFO_DEPTH
) (
    input  wire logic              sys_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              calc_go_i,
    input  wire logic              zero_augment_enable_i,
    input  wire logic              bit_order_select_i,
    input  wire logic [3:0]        poly_length_field_i,
    input  wire logic [3:0]        word_length_field_i,
    input  wire logic              poly_write_i,
    input  wire logic [15:0]       poly_wdata_i,
    output logic      [15:0]       polynomial_coefficients_o,
    input  wire logic              acc_write_i,
    input  wire logic [15:0]       acc_wdata_i,
    output logic      [15:0]       check_accumulator_o,
    input  wire logic              high_byte_write_i,
    input  wire logic              low_byte_write_i,
    input  wire logic [7:0]        byte_wdata_i,
    output logic                   data_pending_o,
    input  wire logic              scanner_go_i,
    input  wire logic              scanner_valid_i,
    input  wire logic [WORD_W-1:0] scanner_word_i,
    output logic                   scanner_ready_o,
    output logic                   busy_o,
    output logic                   calc_done_flag_o,
    input  wire logic              calc_done_flag_clear_i,
    input  wire logic              calc_done_irq_enable_i,
    output logic                   calc_done_irq_o
);
    logic [15:0]       poly_q;
    logic [15:0]       acc_q;
    logic [15:0]       acc_d;
    logic [7:0]        high_byte_q;
    logic [WORD_W-1:0] intermediate_shifter_q;
    logic [4:0]        bits_left_q;
    logic              busy_q;
    logic              busy_prev_q;
    logic              done_q;
    crc_engine_pkg::engine_state_t state_q;
    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic [WORD_W-1:0] fifo_in_data;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;
    logic [WORD_W-1:0] masked_word;
    logic [4:0]        poly_len;
    logic [4:0]        word_len;
    logic [15:0]       top_mask;
    logic [15:0]       keep_mask;
    logic              in_bit;
    logic              fb;
    logic              shifting;
    logic              fifo_empty_idle;

    assign poly_len = {1'b0, poly_length_field_i} + crc_engine_pkg::POLY_LENGTH_FIELD_OFFSET; // RULE1
    assign word_len = {1'b0, word_length_field_i} + crc_engine_pkg::WORD_LENGTH_FIELD_OFFSET; // RULE4
    assign top_mask  = 16'h0001 << poly_length_field_i; // RULE1
    assign keep_mask = top_mask | (top_mask - 16'h0001);

    // software words and scanner words share the fifo; scanner only while its go is set
    assign fifo_in_valid = low_byte_write_i || (scanner_go_i && scanner_valid_i && calc_go_i); // RULE8
    assign fifo_in_data  = low_byte_write_i ? WORD_W'({high_byte_q, byte_wdata_i})
                                            : scanner_word_i;
    assign scanner_ready_o = calc_go_i && fifo_in_ready && !low_byte_write_i; // RULE17
    assign data_pending_o  = !fifo_in_ready; // RULE9

    word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    assign fifo_out_ready = calc_go_i && (state_q == crc_engine_pkg::ST_IDLE);
    assign fifo_empty_idle = !fifo_out_valid && (state_q == crc_engine_pkg::ST_IDLE);

    // mask word to programmed length
    always_comb begin
        masked_word = '0;
        for (int i = 0; i < WORD_W; i++) begin
            if (5'(i) < word_len) begin
                masked_word[i] = fifo_out_data[i]; // RULE3
            end
        end
    end

    // next data bit: lsb when reversed, else the bit at the programmed msb
    always_comb begin
        in_bit = 1'b0;
        if (state_q == crc_engine_pkg::ST_DATA) begin
            if (bit_order_select_i) begin
                in_bit = intermediate_shifter_q[0]; // RULE5
            end else begin
                in_bit = intermediate_shifter_q[word_length_field_i]; // RULE5
            end
        end
    end

    assign shifting = (state_q != crc_engine_pkg::ST_IDLE);

    // augmented-message lfsr: shift in the bit, xor polynomial when top bit falls out
    always_comb begin
        fb    = |(acc_q & top_mask);
        acc_d = ((acc_q << 1) | 16'(in_bit)) & keep_mask;
        if (fb) begin
            acc_d = acc_d ^ ((poly_q | 16'h0001) & keep_mask); // RULE6 RULE2
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            poly_q <= crc_engine_pkg::POLY_RST;
        end else if (poly_write_i) begin
            poly_q <= poly_wdata_i & crc_engine_pkg::POLY_BIT0_MSK; // RULE2
        end
    end
    assign polynomial_coefficients_o = poly_q;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            acc_q <= crc_engine_pkg::ACC_RST;
        end else if (shifting) begin
            acc_q <= acc_d; // RULE6
        end else if (acc_write_i) begin
            acc_q <= acc_wdata_i; // RULE7
        end
    end
    assign check_accumulator_o = acc_q; // RULE16

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            high_byte_q <= crc_engine_pkg::BYTE_RST;
        end else if (high_byte_write_i) begin
            high_byte_q <= byte_wdata_i; // RULE8
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state_q                <= crc_engine_pkg::ST_IDLE;
            intermediate_shifter_q <= '0;
            bits_left_q            <= '0;
        end else begin
            unique case (state_q)
                crc_engine_pkg::ST_IDLE: begin
                    if (fifo_out_valid && calc_go_i) begin
                        intermediate_shifter_q <= masked_word; // RULE14 RULE6
                        bits_left_q            <= word_len; // RULE4
                        state_q                <= crc_engine_pkg::ST_DATA;
                    end
                end
                crc_engine_pkg::ST_DATA: begin
                    intermediate_shifter_q <= bit_order_select_i ? (intermediate_shifter_q >> 1)
                                                                 : (intermediate_shifter_q << 1);
                    bits_left_q <= bits_left_q - 5'd1;
                    if (bits_left_q == 5'd1) begin
                        if (zero_augment_enable_i && !fifo_out_valid) begin
                            bits_left_q <= poly_len - 5'h01; // RULE10
                            state_q     <= crc_engine_pkg::ST_AUG;
                        end else begin
                            state_q <= crc_engine_pkg::ST_IDLE; // RULE11
                        end
                    end
                end
                crc_engine_pkg::ST_AUG: begin
                    bits_left_q <= bits_left_q - 5'd1;
                    if (bits_left_q == 5'h01) begin // RULE10
                        state_q <= crc_engine_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // busy while a word waits or bits remain
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            busy_q      <= 1'b0;
            busy_prev_q <= 1'b0;
        end else begin
            busy_q      <= !fifo_empty_idle || (fifo_in_valid && fifo_in_ready); // RULE18
            busy_prev_q <= busy_q;
        end
    end
    assign busy_o = busy_q;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            done_q <= 1'b0;
        end else if (busy_prev_q && !busy_q) begin
            done_q <= 1'b1; // RULE12
        end else if (calc_done_flag_clear_i) begin
            done_q <= 1'b0; // RULE13
        end
    end
    assign calc_done_flag_o = done_q;
    assign calc_done_irq_o  = done_q && calc_done_irq_enable_i; // RULE12

    AST_BIT0_ZERO: assert property ( // RULE2
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        polynomial_coefficients_o[0] == 1'b0)
        else $error("poly bit0 not zero");
    AST_DONE_ON_FALL: assert property ( // RULE12
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $fell(busy_q) |=> done_q)
        else $error("done not set on busy fall");
    AST_DONE_STICKY: assert property ( // RULE13
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        done_q && !calc_done_flag_clear_i |=> done_q)
        else $error("done cleared by hw");
    AST_IRQ_GATE: assert property ( // RULE12
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        calc_done_irq_o == (done_q && calc_done_irq_enable_i))
        else $error("irq gate");
    AST_READY_GO: assert property ( // RULE17
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        scanner_ready_o |-> calc_go_i)
        else $error("ready without go");
    AST_NO_START_NO_GO: assert property ( // RULE14
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == crc_engine_pkg::ST_IDLE && !calc_go_i
        |=> state_q == crc_engine_pkg::ST_IDLE)
        else $error("shift without go");
    AST_WORD_BITS: assert property ( // RULE4
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == crc_engine_pkg::ST_IDLE ##1 state_q == crc_engine_pkg::ST_DATA
        |-> bits_left_q == word_len)
        else $error("bit count wrong");
    AST_BUSY_SHIFT: assert property ( // RULE18
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $past(shifting) |-> busy_q)
        else $error("not busy while shifting");
    AST_ACC_HOLD: assert property ( // RULE16
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !shifting && !acc_write_i |=> $stable(acc_q))
        else $error("acc changed idle");

    // feedback applies the forced low term; no feedback passes the data bit
    AST_FB_TAP: assert property ( // RULE2
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        shifting && fb |=> check_accumulator_o[0] != $past(in_bit))
        else $error("low term not applied");
    AST_NO_FB: assert property ( // RULE6
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        shifting && !fb |=> check_accumulator_o[0] == $past(in_bit))
        else $error("data bit not shifted in");
    AST_ACC_WIDTH: assert property ( // RULE1
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        shifting |=> (check_accumulator_o & ~keep_mask) == 16'h0000)
        else $error("remainder wider than degree");

    // word loading and bit order
    AST_HIGH_IGNORED: assert property ( // RULE3
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == crc_engine_pkg::ST_IDLE && fifo_out_valid && calc_go_i
        |=> (intermediate_shifter_q >> word_len) == '0)
        else $error("bits above length loaded");
    AST_MSB_SHIFT: assert property ( // RULE5
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == crc_engine_pkg::ST_DATA && !bit_order_select_i
        |=> intermediate_shifter_q == ($past(intermediate_shifter_q) << 1))
        else $error("msb first shift wrong");
    AST_LSB_SHIFT: assert property ( // RULE5
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == crc_engine_pkg::ST_DATA && bit_order_select_i
        |=> intermediate_shifter_q == ($past(intermediate_shifter_q) >> 1))
        else $error("lsb first shift wrong");

    // bit counting and augmentation
    AST_BIT_COUNT: assert property ( // RULE4
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == crc_engine_pkg::ST_DATA && bits_left_q != 5'h01
        |=> state_q == crc_engine_pkg::ST_DATA && bits_left_q == $past(bits_left_q) - 5'h01)
        else $error("data bit count wrong");
    AST_TO_AUG: assert property ( // RULE10
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == crc_engine_pkg::ST_DATA && bits_left_q == 5'h01
        && zero_augment_enable_i && !fifo_out_valid
        |=> state_q == crc_engine_pkg::ST_AUG && bits_left_q == {1'b0, poly_length_field_i} + 5'h01)
        else $error("augment not started");
    AST_NO_AUG: assert property ( // RULE11
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == crc_engine_pkg::ST_DATA && bits_left_q == 5'h01 && !zero_augment_enable_i
        |=> state_q == crc_engine_pkg::ST_IDLE)
        else $error("no stop after last bit");
    AST_AUG_FULL: assert property ( // RULE10
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == crc_engine_pkg::ST_AUG && bits_left_q != 5'h01
        |=> state_q == crc_engine_pkg::ST_AUG)
        else $error("augment cut short");
    AST_AUG_ZERO: assert property ( // RULE10
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == crc_engine_pkg::ST_AUG |-> !in_bit)
        else $error("augment bit not zero");

    AST_SEED_LOAD: assert property ( // RULE7
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !shifting && acc_write_i |=> check_accumulator_o == $past(acc_wdata_i))
        else $error("seed not loaded");

    // done flag and busy
    AST_DONE_CAUSE: assert property ( // RULE12
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(calc_done_flag_o) |-> $past(busy_o, 2) && !$past(busy_o))
        else $error("done set without busy fall");
    AST_CLEAR_WORKS: assert property ( // RULE13
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        calc_done_flag_clear_i && !(busy_prev_q && !busy_q) |=> !calc_done_flag_o)
        else $error("done flag not cleared");

    AST_BUSY_WORD: assert property ( // RULE18
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        fifo_out_valid |=> busy_o)
        else $error("not busy with word queued");

    AST_QUIET_IDLE: assert property ( // RULE16
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !busy_o && !acc_write_i |=> $stable(check_accumulator_o))
        else $error("result moved while idle");
    AST_FALL_EMPTY: assert property ( // RULE16
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $fell(busy_o) |-> state_q == crc_engine_pkg::ST_IDLE && !fifo_out_valid)
        else $error("busy fell with work left");
endmodule : configurable_crc_engine
`default_nettype wire

// *** scanner_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module scanner_model (
    input  wire logic        sys_clk_i,
    input  wire logic        ready_i,
    output logic             go_o,
    output logic             valid_o,
    output logic [15:0]      word_o
);
    initial begin
        go_o    = 1'b0;
        valid_o = 1'b0;
        word_o  = 16'h0000;
    end
    // offers one word after a gap and holds it for up to 200 clocks until the engine takes it
    task automatic send(input logic [15:0] w, input int gap, output logic ok);
        ok = 1'b0;
        repeat (gap) @(negedge sys_clk_i);
        @(negedge sys_clk_i);
        go_o    = 1'b1;
        valid_o = 1'b1;
        word_o  = w;
        for (int i = 0; i < 200; i++) begin
            @(posedge sys_clk_i);
            if (ready_i === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        @(negedge sys_clk_i);
        valid_o = 1'b0;
        word_o  = ~w;
    endtask
    task automatic stop();
        @(negedge sys_clk_i);
        go_o = 1'b0;
    endtask
endmodule // scanner_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, go, aug, ord, pw, aw, hw, lw, clr, ien, ok, busy_p = 1'b0;
    logic [3:0]  poly_length_field, word_length_field;
    logic [15:0] pdat, adat, poly_v, acc_m, w;
    logic [7:0]  bdat;
    logic [31:0] rng = 32'h6;
    wire  [15:0] poly_o, acc_o, sword;
    wire         pend, sgo, sval, srdy, busy, flag, irq;
    int          fails = 0, num_checks = 0, d;
    logic [15:0] exp_q[$];
    always #20 clk = ~clk;
    configurable_crc_engine uut (.sys_clk_i(clk), .reset_n_i(rst_n), .calc_go_i(go),
        .zero_augment_enable_i(aug), .bit_order_select_i(ord), .poly_length_field_i(poly_length_field),
        .word_length_field_i(word_length_field), .poly_write_i(pw), .poly_wdata_i(pdat),
        .polynomial_coefficients_o(poly_o), .acc_write_i(aw), .acc_wdata_i(adat),
        .check_accumulator_o(acc_o), .high_byte_write_i(hw), .low_byte_write_i(lw),
        .byte_wdata_i(bdat), .data_pending_o(pend), .scanner_go_i(sgo), .scanner_valid_i(sval),
        .scanner_word_i(sword), .scanner_ready_o(srdy), .busy_o(busy), .calc_done_flag_o(flag),
        .calc_done_flag_clear_i(clr), .calc_done_irq_enable_i(ien), .calc_done_irq_o(irq));
    scanner_model scan (.sys_clk_i(clk), .ready_i(srdy), .go_o(sgo), .valid_o(sval),
        .word_o(sword));
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [15:0] msk();
        return 16'((32'h1 << d) - 1);
    endfunction
    function automatic void step(input logic b);
        logic fb;
        fb    = acc_m[d-1];
        acc_m = {acc_m[14:0], b} ^ (fb ? (poly_v | 16'h0001) : 16'h0000);
        acc_m = acc_m & msk();
    endfunction
    function automatic void model_word(input logic [15:0] v);
        for (int i = 0; i <= int'(word_length_field); i++) step(ord ? v[i] : v[int'(word_length_field) - i]);
    endfunction
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic set_poly(input logic [15:0] v);
        @(negedge clk);
        pw = 1'b1;
        pdat = v;
        @(negedge clk);
        pw = 1'b0;
        poly_v = v;
        check("poly readback", v & 16'hFFFE, poly_o);
    endtask
    task automatic seed(input logic [15:0] v);
        @(negedge clk);
        aw = 1'b1;
        adat = v;
        @(negedge clk);
        aw = 1'b0;
        acc_m = v;
    endtask
    task automatic wr(input logic [15:0] v);
        @(negedge clk);
        hw = 1'b1;
        bdat = v[15:8];
        @(negedge clk);
        hw = 1'b0;
        lw = 1'b1;
        bdat = v[7:0];
        @(negedge clk);
        lw = 1'b0;
    endtask
    task automatic note();
        if (aug) for (int i = 0; i < d; i++) step(1'b0);
        exp_q.push_back(acc_m);
    endtask
    task automatic wait_done(input string name);
        int n;
        n = 0;
        while (n < 4000 && !(exp_q.size() == 0 && busy === 1'b0)) begin
            @(negedge clk);
            n++;
        end
        if (n == 4000) begin
            fails++;
            final_report();
        end
        repeat (2) @(negedge clk);
        check("done flag", 16'h0001, 16'(flag));
        check("done irq", 16'(ien), 16'(irq));
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        check("done flag cleared", 16'h0000, 16'(flag));
        go = 1'b0;
        $display("test %s done", name);
    endtask
    always @(negedge clk) begin
        if (busy_p === 1'b1 && busy === 1'b0) begin
            if (exp_q.size() == 0) check("spare result", 16'hFFFF, 16'h0000);
            else check("check value", exp_q.pop_front(), acc_o);
        end
        busy_p <= busy;
    end
    initial begin
        {go, aug, ord, pw, aw, hw, lw, clr, ien} = '0;
        {poly_length_field, word_length_field, pdat, adat, bdat} = '0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        check("reset values", 16'h0000, poly_o | acc_o | 16'({busy, flag, pend, irq, srdy}));
        poly_length_field = 4'hF;
        word_length_field = 4'h7;
        aug = 1'b1;
        ien = 1'b1;
        d = 16;
        set_poly(16'h8005);
        for (int o = 0; o < 2; o++) begin
            ord = o[0];
            seed(16'h0000);
            go = 1'b1;
            for (int k = 0; k < 4; k++) wr(16'h0055 + 16'(k * 17));
            exp_q.push_back(o[0] ? 16'h6BA2 : 16'h32D6);
            wait_done("example");
        end
        for (int r = 0; r < 8; r++) begin
            poly_length_field = 4'(rnd());
            word_length_field = 4'(rnd()) | 4'h3;
            {ien, ord, aug} = 3'(r);
            d = int'(poly_length_field) + 1;
            set_poly(16'(rnd()));
            seed(16'(rnd()) & msk());
            go = 1'b1;
            for (int k = 0; k <= r % 4; k++) begin
                w = 16'(rnd());
                wr(w);
                model_word(w);
            end
            note();
            wait_done("random");
        end
        {poly_length_field, word_length_field, aug, ord} = {4'hF, 4'hF, 2'b10};
        d = 16;
        set_poly(16'(rnd()));
        seed(16'(rnd()));
        check("ready without go", 16'h0000, 16'(srdy));
        go = 1'b1;
        for (int k = 0; k < 5; k++) begin
            w = 16'(rnd());
            model_word(w);
            scan.send(w, k, ok);
            check("scanner taken", 16'h0001, 16'(ok));
        end
        scan.stop();
        note();
        wait_done("scanner");
        {poly_length_field, word_length_field, aug, ord} = {4'h7, 4'h7, 2'b11};
        d = 8;
        set_poly(16'(rnd()));
        seed(16'(rnd()) & msk());
        for (int k = 0; k < 17; k++) begin
            w = 16'(rnd());
            if (k == 16) check("pending when full", 16'h0001, 16'(pend));
            wr(w);
            if (k < 16) model_word(w);
        end
        check("busy before go", 16'h0001, 16'(busy));
        go = 1'b1;
        note();
        wait_done("fill");
        check("pending drained", 16'h0000, 16'(pend));
        final_report();
    end
endmodule // testbench
`default_nettype wire
